// ### dcf_pkg.sv
// Constants and types shared by the port-controlled FIFO with programmable flags.
// Assumes a single system clock; both ports are sampled on it.
`default_nettype none

package dcf_pkg;

	localparam int unsigned DATA_W      = 36;
	localparam int unsigned DEPTH_DEF   = 512;

	// Preset offsets chosen by the flag-select straps.
	localparam int unsigned PRESET_HI   = 64;
	localparam int unsigned PRESET_LO   = 8;

	// Strap codes, ordered {flag_prog_sel_hi, flag_prog_sel_lo}.
	localparam logic [1:0]  SEL_SERIAL  = 2'h3;
	localparam logic [1:0]  SEL_PRE_HI  = 2'h2;
	localparam logic [1:0]  SEL_PRE_LO  = 2'h1;
	localparam logic [1:0]  SEL_PARALL  = 2'h0;

	// Edges from a write into empty memory to output-ready high.
	localparam int unsigned OR_LAT      = 3;
	// Edges from a freeing read or filling write to input-ready, almost flags.
	localparam int unsigned FLAG_LAT    = 2;

	// Offset programming and run phases, Gray coded along the usual path.
	typedef enum logic [2:0] {
		MODE_INIT   = 3'h0,
		MODE_PAR_Y  = 3'h1,
		MODE_PAR_X  = 3'h3,
		MODE_RUN    = 3'h2,
		MODE_SERIAL = 3'h6
	} dcf_mode_t;

endpackage : dcf_pkg

`default_nettype wire

// ### dcf_fifo_ports.sv
// Port control, offset programming and status flags of a FIFO from port A to port B.
// Assumes both ports run on the one clock; pins are synchronous to it.
//
// Operation
// - Straps at reset release choose offset loading.
// - Separate offset registers for almost-empty and almost-full.
// - Output-ready low holds word, ignores reads.
// - Read pointer advances per output-register load.
// - First word appears on third edge.
// - Late write starts output sync next cycle.
// - Input-ready low means full, init or serial load; writes ignored.
// - Write pointer advances per stored word.
// - Input-ready rises second edge after read.
// - Late read starts input sync next cycle.
// - Almost-empty compares memory count with offset.
// - Almost-empty rises second edge after write.
// - Late write starts almost-empty sync later.
// - Almost-full compares count with depth minus offset.
// - Almost-full rises second edge after read.
// - Late read starts almost-full sync later.
// - Port A write decode; pins float.
// - Port A read shows mailbox two.
// - Port B read decode for FIFO, mailbox one.
// - Port B write decode for mailbox two.
// - Reset clears pointers, sets flag levels.
// - Parallel mode loads Y then X first.
// - Serial mode shifts Y MSB to X LSB.
// - Mailbox write drops flag, blocks rewrites.
`timescale 1ns/1ns
`default_nettype none

module dcf_fifo_ports
	import dcf_pkg::*;
#(
	parameter int unsigned DEPTH = DEPTH_DEF
) (
	// System.
	input  wire logic              clock,
	input  wire logic              rst,
	// Offset programming straps and serial load.
	input  wire logic              flag_prog_sel_hi,
	input  wire logic              flag_prog_sel_lo,
	// Port A, write side.
	input  wire logic              port_a_select_n,
	input  wire logic              port_a_dir,
	input  wire logic              port_a_strobe,
	input  wire logic              port_a_mail_sel,
	input  wire logic [DATA_W-1:0] port_a_data_in,
	output logic      [DATA_W-1:0] port_a_data_out,
	output logic                   port_a_data_oe,
	// Port B, read side.
	input  wire logic              port_b_select_n,
	input  wire logic              port_b_dir,
	input  wire logic              port_b_strobe,
	input  wire logic              port_b_mail_sel,
	input  wire logic [DATA_W-1:0] port_b_data_in,
	output logic      [DATA_W-1:0] port_b_data_out,
	output logic                   port_b_data_oe,
	// Flags.
	output logic                   input_ready,
	output logic                   output_ready,
	output logic                   almost_empty_n,
	output logic                   almost_full_n,
	output logic                   mail_one_flag_n,
	output logic                   mail_two_flag_n
);

	localparam int unsigned AW  = $clog2(DEPTH);
	localparam int unsigned PW  = AW + 1;
	localparam int unsigned SW  = 2 * AW;
	localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);

	// The serial strobe shares a pin with the high strap, the data with the low one.
	logic serial_offset_in;
	logic serial_load_strobe;
	assign serial_offset_in   = flag_prog_sel_lo;
	assign serial_load_strobe = flag_prog_sel_hi;

	// State.
	logic [DATA_W-1:0] mem [DEPTH];
	dcf_mode_t         mode_ff, nxt_mode;
	logic [AW-1:0]     x_ff, nxt_x, y_ff, nxt_y;
	logic [SW-1:0]     shift_ff, nxt_shift;
	logic [5:0]        bits_ff, nxt_bits;
	logic [PW-1:0]     wr_ff, nxt_wr, rd_ff, nxt_rd, pre_ff, nxt_pre;
	logic [PW-1:0]     wr_d1_ff, rd_d1_ff;
	logic [DATA_W-1:0] buf_ff [2];
	logic [DATA_W-1:0] nxt_buf [2];
	logic              head_ff, nxt_head;
	logic [1:0]        fill_ff, nxt_fill;
	logic [DATA_W-1:0] word_ff, nxt_word;
	logic [DATA_W-1:0] mail1_ff, nxt_mail1, mail2_ff, nxt_mail2;
	logic              or_ff, nxt_or, ir_ff, nxt_ir, ae_ff, nxt_ae, af_ff, nxt_af;
	logic              mf1_ff, nxt_mf1, mf2_ff, nxt_mf2;
	logic [DATA_W-1:0] a_out_ff, nxt_a_out, b_out_ff, nxt_b_out;
	logic              a_oe_ff, nxt_a_oe, b_oe_ff, nxt_b_oe;

	// Port decode.
	logic a_fifo_wr, a_mail_wr, a_mail_rd, b_fifo_rd, b_mail_rd, b_mail_wr;
	logic mem_wr, buf_push, buf_pop;
	logic [PW-1:0] cnt_b, cnt_a;

	always_comb begin
		a_fifo_wr = !port_a_select_n && port_a_dir && port_a_strobe && !port_a_mail_sel
			&& ir_ff;
		a_mail_wr = !port_a_select_n && port_a_dir && port_a_strobe && port_a_mail_sel;
		a_mail_rd = !port_a_select_n && !port_a_dir && port_a_strobe && port_a_mail_sel;
		b_fifo_rd = !port_b_select_n && port_b_dir && port_b_strobe && !port_b_mail_sel
			&& or_ff;
		b_mail_rd = !port_b_select_n && port_b_dir && port_b_strobe && port_b_mail_sel;
		b_mail_wr = !port_b_select_n && !port_b_dir && port_b_strobe && port_b_mail_sel;
		mem_wr    = a_fifo_wr && (mode_ff == MODE_RUN);
		// Prefetch only words whose write has crossed one sync stage, so the word
		// reaches the output register on the third edge after its write.
		buf_push  = (fill_ff != 2'h2) && (pre_ff != wr_d1_ff);
		buf_pop   = (fill_ff != 2'h0) && (!or_ff || b_fifo_rd);
	end

	// Offset programming.
	always_comb begin
		nxt_mode  = mode_ff;
		nxt_x     = x_ff;
		nxt_y     = y_ff;
		nxt_shift = shift_ff;
		nxt_bits  = bits_ff;
		case (mode_ff)
			MODE_INIT: begin
				// Straps are caught on the first edge after release, not under reset.
				case ({flag_prog_sel_hi, flag_prog_sel_lo})
					SEL_SERIAL: nxt_mode = MODE_SERIAL;
					SEL_PRE_HI: begin
						nxt_x    = AW'(PRESET_HI);
						nxt_y    = AW'(PRESET_HI);
						nxt_mode = MODE_RUN;
					end
					SEL_PRE_LO: begin
						nxt_x    = AW'(PRESET_LO);
						nxt_y    = AW'(PRESET_LO);
						nxt_mode = MODE_RUN;
					end
					default: nxt_mode = MODE_PAR_Y;
				endcase
			end
			MODE_PAR_Y: begin
				if (a_fifo_wr) begin
					nxt_y    = port_a_data_in[AW-1:0];
					nxt_mode = MODE_PAR_X;
				end
			end
			MODE_PAR_X: begin
				if (a_fifo_wr) begin
					nxt_x    = port_a_data_in[AW-1:0];
					nxt_mode = MODE_RUN;
				end
			end
			MODE_SERIAL: begin
				if (!serial_load_strobe) begin
					nxt_shift = {shift_ff[SW-2:0], serial_offset_in};
					nxt_bits  = bits_ff + 6'h01;
					if (bits_ff == 6'(SW - 1)) begin
						nxt_y    = shift_ff[SW-2:AW-1];
						nxt_x    = {shift_ff[AW-2:0], serial_offset_in};
						nxt_mode = MODE_RUN;
					end
				end
			end
			MODE_RUN: nxt_mode = MODE_RUN;
			default:  nxt_mode = MODE_INIT;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode_ff  <= MODE_INIT;
			x_ff     <= '0;
			y_ff     <= '0;
			shift_ff <= '0;
			bits_ff  <= 6'h00;
		end else begin
			mode_ff  <= nxt_mode;
			x_ff     <= nxt_x;
			y_ff     <= nxt_y;
			shift_ff <= nxt_shift;
			bits_ff  <= nxt_bits;
		end
	end

	// Pointers, two-entry prefetch buffer and output register.
	always_comb begin
		nxt_wr   = wr_ff + PW'(mem_wr);
		nxt_pre  = pre_ff + PW'(buf_push);
		nxt_rd   = rd_ff + PW'(buf_pop);
		nxt_buf  = buf_ff;
		nxt_head = head_ff ^ buf_pop;
		nxt_fill = fill_ff + 2'(buf_push) - 2'(buf_pop);
		if (buf_push) begin
			nxt_buf[head_ff ^ (fill_ff != 2'h0)] = mem[pre_ff[AW-1:0]];
		end
		nxt_word = buf_pop ? buf_ff[head_ff] : word_ff;
		nxt_or   = buf_pop || (or_ff && !b_fifo_rd);
	end

	// Counts exclude the output register; each side sees the far pointer one stage late.
	assign cnt_b = wr_d1_ff - nxt_rd;
	assign cnt_a = nxt_wr - rd_d1_ff;

	always_comb begin
		nxt_ir = (mode_ff != MODE_INIT) && (mode_ff != MODE_SERIAL) && (cnt_a < DEPTH_P);
		nxt_ae = cnt_b > {1'b0, x_ff};
		nxt_af = cnt_a <= (DEPTH_P - {1'b0, y_ff} - PW'(1));
	end

	always_ff @(posedge clock) begin
		if (mem_wr) begin
			mem[wr_ff[AW-1:0]] <= port_a_data_in;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ff    <= '0;
			rd_ff    <= '0;
			pre_ff   <= '0;
			wr_d1_ff <= '0;
			rd_d1_ff <= '0;
			buf_ff   <= '{default: '0};
			head_ff  <= 1'b0;
			fill_ff  <= 2'h0;
			word_ff  <= '0;
			or_ff    <= 1'b0;
			ir_ff    <= 1'b0;
			ae_ff    <= 1'b0;
			af_ff    <= 1'b1;
		end else begin
			wr_ff    <= nxt_wr;
			rd_ff    <= nxt_rd;
			pre_ff   <= nxt_pre;
			wr_d1_ff <= wr_ff;
			rd_d1_ff <= rd_ff;
			buf_ff   <= nxt_buf;
			head_ff  <= nxt_head;
			fill_ff  <= nxt_fill;
			word_ff  <= nxt_word;
			or_ff    <= nxt_or;
			ir_ff    <= nxt_ir;
			ae_ff    <= nxt_ae;
			af_ff    <= nxt_af;
		end
	end

	// Mailboxes and pin drivers.
	always_comb begin
		nxt_mail1 = mail1_ff;
		nxt_mail2 = mail2_ff;
		nxt_mf1   = mf1_ff;
		nxt_mf2   = mf2_ff;
		// A write wins over a same-cycle read only while the flag is high; a write in the same cycle as a read of held mail is dropped.
		if (b_mail_rd) nxt_mf1 = 1'b1;
		if (a_mail_rd) nxt_mf2 = 1'b1;
		if (a_mail_wr && mf1_ff) begin
			nxt_mail1 = port_a_data_in;
			nxt_mf1   = 1'b0;
		end
		if (b_mail_wr && mf2_ff) begin
			nxt_mail2 = port_b_data_in;
			nxt_mf2   = 1'b0;
		end
		// Pins are registered, so enables and data follow the controls one edge late.
		nxt_a_oe  = !port_a_select_n && !port_a_dir;
		nxt_a_out = nxt_mail2;
		nxt_b_oe  = !port_b_select_n && port_b_dir;
		nxt_b_out = port_b_mail_sel ? nxt_mail1 : nxt_word;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mail1_ff <= '0;
			mail2_ff <= '0;
			mf1_ff   <= 1'b1;
			mf2_ff   <= 1'b1;
			a_oe_ff  <= 1'b0;
			a_out_ff <= '0;
			b_oe_ff  <= 1'b0;
			b_out_ff <= '0;
		end else begin
			mail1_ff <= nxt_mail1;
			mail2_ff <= nxt_mail2;
			mf1_ff   <= nxt_mf1;
			mf2_ff   <= nxt_mf2;
			a_oe_ff  <= nxt_a_oe;
			a_out_ff <= nxt_a_out;
			b_oe_ff  <= nxt_b_oe;
			b_out_ff <= nxt_b_out;
		end
	end

	assign port_a_data_out = a_out_ff;
	assign port_a_data_oe  = a_oe_ff;
	assign port_b_data_out = b_out_ff;
	assign port_b_data_oe  = b_oe_ff;
	assign input_ready     = ir_ff;
	assign output_ready    = or_ff;
	assign almost_empty_n  = ae_ff;
	assign almost_full_n   = af_ff;
	assign mail_one_flag_n = mf1_ff;
	assign mail_two_flag_n = mf2_ff;

	// Checks.
	logic [PW-1:0] cnt_now;
	assign cnt_now = wr_ff - rd_ff;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	preset_lo_a: assert property (mode_ff == MODE_INIT && !flag_prog_sel_hi && flag_prog_sel_lo
		|=> x_ff == AW'(PRESET_LO) && y_ff == AW'(PRESET_LO))
		else $error("preset offset not loaded");
	out_hold_a: assert property (!or_ff ##1 !or_ff |-> $stable(word_ff))
		else $error("output word changed while not ready");
	rd_step_a: assert property (buf_pop |=> rd_ff == $past(rd_ff) + PW'(1))
		else $error("read pointer did not advance");
	first_word_a: assert property (mem_wr && cnt_now == '0 && !or_ff
		|=> !or_ff ##1 !or_ff ##1 !or_ff ##1 or_ff)
		else $error("first word not shown on third edge");
	full_block_a: assert property (cnt_now == DEPTH_P |-> !ir_ff)
		else $error("input ready while memory full");
	ir_return_a: assert property (buf_pop && cnt_now == DEPTH_P && mode_ff == MODE_RUN
		|=> !ir_ff ##1 !ir_ff ##1 ir_ff)
		else $error("input ready not back on second edge");
	ae_rise_a: assert property ((mem_wr && !buf_pop && cnt_now == {1'b0, x_ff})
		##1 !buf_pop ##1 !buf_pop |-> !ae_ff ##1 ae_ff)
		else $error("almost empty did not rise on second edge");
	af_rise_a: assert property ((buf_pop && !mem_wr
		&& cnt_now == DEPTH_P - {1'b0, y_ff}) ##1 !mem_wr ##1 !mem_wr |-> !af_ff ##1 af_ff)
		else $error("almost full did not rise on second edge");
	par_load_a: assert property (mode_ff == MODE_PAR_Y && a_fifo_wr
		|=> wr_ff == $past(wr_ff) && y_ff == $past(port_a_data_in[AW-1:0]))
		else $error("parallel load stored data");
	mail_lock_a: assert property (a_mail_wr && !mf1_ff |=> $stable(mail1_ff))
		else $error("mailbox overwritten while flag low");

	or_rise_c: cover property (!or_ff ##1 or_ff);
	ir_full_c: cover property (ir_ff ##1 !ir_ff);
	mail_c: cover property (a_mail_wr && mf1_ff ##[1:20] b_mail_rd);
	serial_c: cover property (mode_ff == MODE_SERIAL ##[1:60] mode_ff == MODE_RUN);

endmodule : dcf_fifo_ports

`default_nettype wire

// ### dcf_pin_model.sv
// Pin-level model of the data lines that the bus masters share with the FIFO ports.
// Assumes the port's registered output enable and data, sampled on the one system clock.
`timescale 1ns/1ns
`default_nettype none

module dcf_pin_model
	import dcf_pkg::*;
(
	// System.
	input  wire logic              clock,
	input  wire logic              rst,
	// Port drive from the design.
	input  wire logic [DATA_W-1:0] drv_data,
	input  wire logic              drv_oe,
	// Level that a master sees on the lines.
	output logic      [DATA_W-1:0] pin_level
);
	logic [DATA_W-1:0] last_ff;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			last_ff <= '0;
		end else if (drv_oe) begin
			last_ff <= drv_data;
		end
	end

	// Released lines show the inverse of the last driven word, so a stale read never matches.
	assign pin_level = drv_oe ? drv_data : ~last_ff;
endmodule // dcf_pin_model

`default_nettype wire

// ### dcf_fifo_ports_tb_top.sv
// Self-checking bench for the FIFO port control, offset programming and flags.
// Assumes a single system clock for both ports and pin models on both data buses.
`timescale 1ns/1ns
`default_nettype none

module dcf_fifo_ports_tb_top
	import dcf_pkg::*;
;
	// A small depth keeps full and empty within a few dozen cycles.
	localparam int unsigned DP = 16;
	localparam logic [3:0]  YO = 4'h3;
	localparam logic [3:0]  XO = 4'h2;
	localparam logic [7:0]  SER = 8'h32;

	logic              clock = 1'b0, rst = 1'b1, fhi = 1'b0, flo = 1'b0;
	logic              a_sel_n = 1'b1, a_dir = 1'b0, a_stb = 1'b0, a_mail = 1'b0;
	logic              b_sel_n = 1'b1, b_dir = 1'b0, b_stb = 1'b0, b_mail = 1'b0;
	logic [DATA_W-1:0] a_din = '0, b_din = '0, a_dout, b_dout, bus_a, bus_b;
	logic              a_oe, b_oe, ir, orr, ae_n, af_n, m1_n, m2_n, ir_seen;
	int                bad_count = 0, cmp_count = 0, n, k, mem;

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end

	always #4 clock = ~clock;

	dcf_fifo_ports #(.DEPTH(DP)) dcf_fifo_ports_i (
		.clock(clock), .rst(rst), .flag_prog_sel_hi(fhi), .flag_prog_sel_lo(flo),
		.port_a_select_n(a_sel_n), .port_a_dir(a_dir), .port_a_strobe(a_stb),
		.port_a_mail_sel(a_mail), .port_a_data_in(a_din), .port_a_data_out(a_dout),
		.port_a_data_oe(a_oe), .port_b_select_n(b_sel_n), .port_b_dir(b_dir),
		.port_b_strobe(b_stb), .port_b_mail_sel(b_mail), .port_b_data_in(b_din),
		.port_b_data_out(b_dout), .port_b_data_oe(b_oe), .input_ready(ir),
		.output_ready(orr), .almost_empty_n(ae_n), .almost_full_n(af_n),
		.mail_one_flag_n(m1_n), .mail_two_flag_n(m2_n));
	dcf_pin_model dcf_pin_model_i (.clock(clock), .rst(rst), .drv_data(a_dout),
		.drv_oe(a_oe), .pin_level(bus_a));
	dcf_pin_model dcf_pin_model_b_i (.clock(clock), .rst(rst), .drv_data(b_dout),
		.drv_oe(b_oe), .pin_level(bus_b));

	function automatic logic [DATA_W-1:0] pat(input int i);
		return 36'h9_0000_0000 | DATA_W'(i);
	endfunction

	task automatic tick(input int c);
		repeat (c) @(posedge clock);
		#1;
	endtask

	task automatic a_op(input logic d, input logic m, input logic [DATA_W-1:0] v);
		@(posedge clock);
		a_sel_n <= 1'b0;
		a_dir <= d;
		a_mail <= m;
		a_stb <= 1'b1;
		a_din <= v;
		@(posedge clock);
		a_stb <= 1'b0;
		#1;
	endtask

	task automatic b_op(input logic d, input logic m, input logic [DATA_W-1:0] v);
		@(posedge clock);
		b_sel_n <= 1'b0;
		b_dir <= d;
		b_mail <= m;
		b_stb <= 1'b1;
		b_din <= v;
		@(posedge clock);
		b_stb <= 1'b0;
		#1;
	endtask

	task automatic do_reset(input logic [1:0] code);
		@(posedge clock);
		rst <= 1'b1;
		{fhi, flo} <= code;
		a_sel_n <= 1'b1;
		b_sel_n <= 1'b1;
		repeat (5) @(posedge clock);
		#1;
		`CHK("reset flags", 6'h07, {ir, orr, ae_n, af_n, m1_n, m2_n})
		@(posedge clock);
		rst <= 1'b0;
		tick(1);
		`CHK("ready at edge one", 1'b0, ir)
		if (code != SEL_SERIAL) begin
			tick(1);
			`CHK("ready at edge two", 1'b1, ir)
		end
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		final_report;
	end

	initial begin
		do_reset(SEL_PARALL);
		a_op(1'b1, 1'b0, DATA_W'(YO));
		a_op(1'b1, 1'b0, DATA_W'(XO));
		// Strobe stays high; a write only counts on edges that saw input-ready high.
		@(posedge clock);
		a_sel_n <= 1'b0;
		a_stb <= 1'b1;
		a_din <= pat(0);
		n = 0;
		// Input-ready is read at the falling edge, where it has settled for the next rise.
		for (k = 0; k < 40; k++) begin
			@(negedge clock);
			ir_seen = ir;
			@(posedge clock);
			if (ir_seen === 1'b1) begin
				n++;
				a_din <= pat(n);
			end
		end
		a_stb <= 1'b0;
		tick(3);
		`CHK("accepted words", DP + 1, n)
		`CHK("flags when full", 4'h6, {ir, orr, ae_n, af_n})
		$display("test fill done");
		@(posedge clock);
		b_sel_n <= 1'b0;
		b_dir <= 1'b1;
		b_mail <= 1'b0;
		tick(2);
		for (k = 1; k <= DP + 1; k++) begin
			`CHK("fifo word", pat(k - 1), bus_b)
			b_op(1'b1, 1'b0, '0);
			tick(1);
			if (k == 1) `CHK("ready one edge after read", 1'b0, ir)
			tick(1);
			if (k == 1) `CHK("ready two edges after read", 1'b1, ir)
			tick(1);
			mem = (k > DP) ? 0 : DP - k;
			`CHK("almost full", (mem <= DP - YO - 1), af_n)
			`CHK("almost empty", (mem > XO), ae_n)
		end
		`CHK("output ready when empty", 1'b0, orr)
		b_op(1'b1, 1'b0, '0);
		tick(2);
		`CHK("held word", pat(DP), bus_b)
		$display("test drain done");
		a_op(1'b1, 1'b1, 36'h1_2345_6789);
		tick(1);
		`CHK("mail one flag", 1'b0, m1_n)
		`CHK("port a float on write", 1'b0, a_oe)
		a_op(1'b1, 1'b1, 36'h0_0BAD_0000);
		b_op(1'b1, 1'b1, '0);
		tick(1);
		`CHK("mail one word", 36'h1_2345_6789, bus_b)
		`CHK("mail one flag read", 1'b1, m1_n)
		b_op(1'b0, 1'b0, 36'h0_0000_00FF);
		tick(1);
		`CHK("mail two untouched", 1'b1, m2_n)
		`CHK("port b float on write", 1'b0, b_oe)
		b_op(1'b0, 1'b1, 36'hA_BCDE_F012);
		tick(1);
		`CHK("mail two flag", 1'b0, m2_n)
		a_op(1'b0, 1'b1, '0);
		tick(1);
		`CHK("mail two word", 36'hA_BCDE_F012, bus_a)
		`CHK("mail two flag read", 1'b1, m2_n)
		$display("test mailbox done");
		do_reset(SEL_PRE_HI);
		do_reset(SEL_PRE_LO);
		do_reset(SEL_SERIAL);
		for (k = 7; k >= 0; k--) begin
			@(posedge clock);
			fhi <= 1'b0;
			flo <= SER[k];
		end
		@(posedge clock);
		fhi <= 1'b1;
		#1;
		`CHK("ready on last bit", 1'b0, ir)
		tick(1);
		`CHK("ready after last bit", 1'b1, ir)
		repeat (3) a_op(1'b1, 1'b0, pat(0));
		tick(4);
		`CHK("almost empty at offset", 1'b0, ae_n)
		a_op(1'b1, 1'b0, pat(1));
		tick(1);
		`CHK("almost empty one edge", 1'b0, ae_n)
		tick(1);
		`CHK("almost empty two edges", 1'b1, ae_n)
		$display("test modes done");
		// Let pending flag assertions see their last edges before the run ends.
		tick(2);
		final_report;
	end
endmodule // dcf_fifo_ports_tb_top

`default_nettype wire
